// *** rtl/dbg_ext_pkg.sv ***
/*
  Shared constants and carrier types for the debug comparator C extension
  and trace word extension logic.
  Assumes a single bus clock and an AXI4-Lite register port with 32-bit
  data; registers sit at four times their index.
*/
package dbg_ext_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned AXI_ADDR_WIDTH = 8;
  localparam logic [AXI_ADDR_WIDTH-1:0] IDX_COMP_C_EXT = 8'h0a;
  localparam logic [AXI_ADDR_WIDTH-1:0] IDX_TRACE_EXT  = 8'h0b;

  // Field positions inside the 8-bit registers
  localparam int unsigned POS_DIR_QUALIFY_ENABLE  = 7;
  localparam int unsigned POS_DIR_MATCH_VALUE     = 6;
  localparam int unsigned POS_PAGE_QUALIFY_SELECT = 5;
  localparam int unsigned POS_PAGED_ACCESS_FLAG   = 7;
  localparam int unsigned POS_ADDR16              = 0;

  // Reset values of both extension registers
  localparam logic [7:0] RESET_COMP_C_EXT = 8'h00;
  localparam logic [7:0] RESET_TRACE_EXT  = 8'h00;

  // Core address layout
  localparam int unsigned CORE_ADDR_WIDTH = 17;
  localparam int unsigned PAGE_WIDTH      = 3;
  localparam int unsigned PAGE_OFFSET_W   = 14;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Comparator C extra qualifiers
  typedef struct packed {
    logic dir_qualify_enable;
    logic dir_match_value;
    logic page_qualify_select;
    logic addr16;
  } comp_c_ext_type;

  // Extended information of the current trace word
  typedef struct packed {
    logic paged_access_flag;
    logic addr16;
  } trace_ext_type;

  // One core bus cycle as seen by the comparator
  typedef struct packed {
    logic                       valid;
    logic                       read;
    logic                       paged_access_flag;
    logic [CORE_ADDR_WIDTH-1:0] addr;
  } core_bus_type;

  // Register selected by a bus address
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_COMP_C,
    SEL_TRACE
  } reg_sel_type;

  // Complete state of the register block
  typedef struct packed {
    logic                      aw_held;
    logic [AXI_ADDR_WIDTH-1:0] aw_addr;
    logic                      w_held;
    logic [7:0]                w_byte;
    logic                      w_lane0;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    comp_c_ext_type            comp_c;
    trace_ext_type             trace;
    logic                      hit;
  } ext_state_type;

endpackage

// *** rtl/comp_c_ext_match.sv ***
/*
  Combinational qualifier check for comparator C: direction, paged
  access and address bit 16.
  Assumes the core presents the 17-bit address already formed, paged
  page bits on top when the paged access flag is set.
*/
module comp_c_ext_match (
  input  wire dbg_ext_pkg::comp_c_ext_type ext,
  input  wire dbg_ext_pkg::core_bus_type   bus,
  output logic                             qualified
);

  logic dir_ok;
  logic page_ok;
  logic bit16_ok;

  // Direction only counts when qualification is on; read is 1, write 0
  assign dir_ok = !ext.dir_qualify_enable
                  || (bus.read == ext.dir_match_value);

  // Paged flag must equal the select in both settings
  assign page_ok = (bus.paged_access_flag
                    == ext.page_qualify_select);

  // Top address bit against the stored bit
  assign bit16_ok = (bus.addr[dbg_ext_pkg::CORE_ADDR_WIDTH-1]
                     == ext.addr16);

  assign qualified = bus.valid && dir_ok && page_ok && bit16_ok;

endmodule

// *** rtl/dbg_ext_regs.sv ***
/*
  Debug comparator C extension register and trace word extension
  information register, reached over AXI4-Lite, with the comparator C
  qualifier check.
  Assumes one bus clock, a synchronous active-low reset, a reset-cause
  level from the reset controller, and a trace sequencer that pulses
  when the current trace word changes.
*/
module dbg_ext_regs #(
  parameter int unsigned ADDR_WIDTH = dbg_ext_pkg::AXI_ADDR_WIDTH
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_WIDTH-1:0]         s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]         s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Reset cause and debug control levels
  input  wire logic                          end_trace_reset,
  input  wire logic                          debug_module_enable,
  input  wire logic                          trigger_begin_select,
  // Core bus cycle and trace word capture
  input  wire dbg_ext_pkg::core_bus_type     core_bus,
  input  wire logic                          trace_word_load,
  input  wire dbg_ext_pkg::trace_ext_type    trace_word_info,
  // Qualifiers to the comparator C core, trace word information and match result
  output dbg_ext_pkg::comp_c_ext_type        comp_c_ext,
  output dbg_ext_pkg::trace_ext_type         trace_ext,
  output logic                               comp_c_ext_hit
);

  dbg_ext_pkg::ext_state_type state;
  dbg_ext_pkg::ext_state_type next_state;
  logic                       qualified;
  logic                       retain;

  // Map a byte address to a register; low two bits must be zero
  function automatic dbg_ext_pkg::reg_sel_type
      decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [ADDR_WIDTH-1:0] idx;
    idx = addr >> 2;
    if (addr[1:0] != 2'h0) begin
      return dbg_ext_pkg::SEL_NONE;
    end else if (idx == dbg_ext_pkg::IDX_COMP_C_EXT) begin
      return dbg_ext_pkg::SEL_COMP_C;
    end else if (idx == dbg_ext_pkg::IDX_TRACE_EXT) begin
      return dbg_ext_pkg::SEL_TRACE;
    end else begin
      return dbg_ext_pkg::SEL_NONE;
    end
  endfunction

  // Pack the comparator C fields; bits 4:1 stay zero
  function automatic logic [7:0] pack_comp_c(
      input dbg_ext_pkg::comp_c_ext_type f);
    logic [7:0] v;
    v = 8'h00;
    v[dbg_ext_pkg::POS_DIR_QUALIFY_ENABLE]  = f.dir_qualify_enable;
    v[dbg_ext_pkg::POS_DIR_MATCH_VALUE]     = f.dir_match_value;
    v[dbg_ext_pkg::POS_PAGE_QUALIFY_SELECT] = f.page_qualify_select;
    v[dbg_ext_pkg::POS_ADDR16]              = f.addr16;
    return v;
  endfunction

  // Pack the trace word fields; all other bits read zero
  function automatic logic [7:0] pack_trace(
      input dbg_ext_pkg::trace_ext_type f);
    logic [7:0] v;
    v = 8'h00;
    v[dbg_ext_pkg::POS_PAGED_ACCESS_FLAG] = f.paged_access_flag;
    v[dbg_ext_pkg::POS_ADDR16]            = f.addr16;
    return v;
  endfunction

  // Qualifier check kept apart so the comparator core can reuse it
  comp_c_ext_match u_match (
    .ext       (state.comp_c),
    .bus       (core_bus),
    .qualified (qualified)
  );

  // Retention holds only for an end-trace reset that ends the store
  // window; a begin-trigger run has nothing worth keeping at the end
  assign retain = end_trace_reset && debug_module_enable
                  && !trigger_begin_select;

  // Handshake outputs follow the state directly
  assign s_axi_awready = !state.aw_held && !state.bvalid;
  assign s_axi_wready  = !state.w_held && !state.bvalid;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;

  // Data outputs come from flip-flops
  assign comp_c_ext     = state.comp_c;
  assign trace_ext      = state.trace;
  assign comp_c_ext_hit = state.hit;

  // Next state of the whole block
  always_comb begin
    dbg_ext_pkg::reg_sel_type wsel;
    dbg_ext_pkg::reg_sel_type rsel;
    logic [7:0]               rbyte;
    next_state = state;
    wsel       = dbg_ext_pkg::SEL_NONE;
    rsel       = dbg_ext_pkg::SEL_NONE;
    rbyte      = 8'h00;

    // Write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_state.w_held  = 1'b1;
      next_state.w_byte  = s_axi_wdata[7:0];
      next_state.w_lane0 = s_axi_wstrb[0];
    end

    // Response leaves once the master takes it
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // Perform the write once both halves are present
    if (next_state.aw_held && next_state.w_held && !state.bvalid) begin
      wsel              = decode(next_state.aw_addr);
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = dbg_ext_pkg::RESP_OKAY;
      case (wsel)
        dbg_ext_pkg::SEL_COMP_C: begin
          // Only byte lane 0 carries the register; other lanes ignored
          if (next_state.w_lane0) begin
            next_state.comp_c.dir_qualify_enable =
              next_state.w_byte[dbg_ext_pkg::POS_DIR_QUALIFY_ENABLE];
            next_state.comp_c.dir_match_value =
              next_state.w_byte[dbg_ext_pkg::POS_DIR_MATCH_VALUE];
            next_state.comp_c.page_qualify_select =
              next_state.w_byte[dbg_ext_pkg::POS_PAGE_QUALIFY_SELECT];
            next_state.comp_c.addr16 =
              next_state.w_byte[dbg_ext_pkg::POS_ADDR16];
          end
        end
        dbg_ext_pkg::SEL_TRACE: begin
          // Read-only: the write is answered but changes nothing
          next_state.bresp = dbg_ext_pkg::RESP_OKAY;
        end
        default: begin
          next_state.bresp = dbg_ext_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read data is latched when the address is taken
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rsel = decode(s_axi_araddr);
      next_state.rvalid = 1'b1;
      next_state.rresp  = dbg_ext_pkg::RESP_OKAY;
      case (rsel)
        dbg_ext_pkg::SEL_COMP_C: begin
          rbyte = pack_comp_c(state.comp_c);
        end
        dbg_ext_pkg::SEL_TRACE: begin
          rbyte = pack_trace(state.trace);
        end
        default: begin
          rbyte            = 8'h00;
          next_state.rresp = dbg_ext_pkg::RESP_SLVERR;
        end
      endcase
      next_state.rdata = {24'h000000, rbyte};
    end

    // Outside a reset, trace info changes only with the trace word itself
    if (trace_word_load) begin
      next_state.trace = trace_word_info;
    end

    // Match result one cycle after the core cycle
    next_state.hit = qualified;

    // Reset clears the bus side always; the extension fields survive an
    // end-trace reset with debug enabled and no begin trigger, so the debugger can read the run afterwards
    if (!aresetn) begin
      next_state = '0;
      if (retain) begin
        next_state.comp_c = state.comp_c;
        next_state.trace  = state.trace;
      end else begin
        next_state.comp_c = dbg_ext_pkg::comp_c_ext_type'(
          {dbg_ext_pkg::RESET_COMP_C_EXT[7:5],
           dbg_ext_pkg::RESET_COMP_C_EXT[0]});
        next_state.trace = dbg_ext_pkg::trace_ext_type'(
          {dbg_ext_pkg::RESET_TRACE_EXT[7],
           dbg_ext_pkg::RESET_TRACE_EXT[0]});
      end
    end
  end

  // One register for the whole state; reset handled in the next value
  always_ff @(posedge aclk) begin
    state <= next_state;
  end

endmodule

// *** tb/core_bus_model.sv ***
/*
  Model of the CPU core side: bus cycles with the paged access flag and
  the trace word change pulse with its extended information.
  Assumes the bench calls its tasks right after a rising clock edge.
*/
module core_bus_model (
  input  wire logic                 aclk,
  output dbg_ext_pkg::core_bus_type core_bus,
  output logic                      trace_word_load,
  output dbg_ext_pkg::trace_ext_type trace_word_info
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus until the first cycle
  initial begin
    core_bus = '0;
    trace_word_load = 1'b0;
    trace_word_info = '0;
  end

  // One bus cycle; paged forms page:offset, unpaged a linear address
  task automatic drive(input logic rd, input logic pg, input logic a16);
    logic [16:0] a;
    a = pg ? {a16, 2'h2, 14'h0a5c} : {a16, 16'h3c5a};
    @(posedge aclk);
    core_bus <= '{1'b1, rd, pg, a};
    @(posedge aclk);
    // Released bus shows inverted values so stale data never matches
    core_bus <= '{1'b0, ~rd, ~pg, ~a};
  endtask

  // One-cycle pulse when the current trace word changes
  task automatic load(input logic pg, input logic a16);
    @(posedge aclk);
    trace_word_load <= 1'b1;
    trace_word_info <= '{pg, a16};
    @(posedge aclk);
    trace_word_load <= 1'b0;
    trace_word_info <= '{~pg, ~a16};
  endtask
endmodule

// *** tb/dbg_ext_regs_chk.sv ***
/*
  Assertion checker for the comparator C and trace word extension block.
  Assumes it is bound to dbg_ext_regs and sees only its ports.
*/
module dbg_ext_regs_chk (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        end_trace_reset,
  input wire logic                        debug_module_enable,
  input wire logic                        trigger_begin_select,
  input wire dbg_ext_pkg::core_bus_type   core_bus,
  input wire logic                        trace_word_load,
  input wire dbg_ext_pkg::trace_ext_type  trace_word_info,
  input wire dbg_ext_pkg::comp_c_ext_type comp_c_ext,
  input wire dbg_ext_pkg::trace_ext_type  trace_ext,
  input wire logic                        comp_c_ext_hit,
  input wire logic                        s_axi_rvalid,
  input wire logic [31:0]                 s_axi_rdata
);
  dbg_ext_pkg::comp_c_ext_type e;
  dbg_ext_pkg::core_bus_type   b;
  logic                        keep;

  // Short aliases and the retention condition
  assign e = comp_c_ext;
  assign b = core_bus;
  assign keep = end_trace_reset && debug_module_enable && !trigger_begin_select;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Hit follows the qualifiers of the previous cycle
  dir_ignore_a: assert property (b.valid && !e.dir_qualify_enable &&
    e.page_qualify_select == b.paged_access_flag && e.addr16 == b.addr[16]
    |=> comp_c_ext_hit) else $error("hit missing with direction ignored");
  dir_value_a: assert property (b.valid && e.dir_qualify_enable &&
    b.read != e.dir_match_value |=> !comp_c_ext_hit)
    else $error("hit on wrong direction");
  page_zero_a: assert property (b.valid && !e.page_qualify_select &&
    b.paged_access_flag |=> !comp_c_ext_hit) else $error("hit on paged");
  page_one_a: assert property (b.valid && e.page_qualify_select &&
    !b.paged_access_flag |=> !comp_c_ext_hit) else $error("hit on unpaged");
  addr_bit_a: assert property (b.valid && b.addr[16] != e.addr16
    |=> !comp_c_ext_hit) else $error("hit on wrong address bit 16");
  // Reset disables the others, so its outcome is judged at release
  reset_clear_a: assert property ($past(!aresetn && !keep) |->
    comp_c_ext == '0 && trace_ext == '0) else $error("reset did not clear");
  reset_keep_a: assert property ($past(!aresetn && keep) |->
    $stable(comp_c_ext) && $stable(trace_ext)) else $error("retention lost");
  trace_load_a: assert property (trace_word_load |=>
    trace_ext == $past(trace_word_info)) else $error("trace info not taken");
  trace_hold_a: assert property (!trace_word_load |=>
    $stable(trace_ext)) else $error("trace info changed without load");
  read_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
    && s_axi_rdata[4:1] == 4'h0) else $error("unused read bits set");

  // Main scenarios
  cover property (comp_c_ext_hit);
  cover property (aresetn && $past(!aresetn && keep));
  cover property (trace_word_load);
endmodule

bind dbg_ext_regs dbg_ext_regs_chk u_dbg_ext_regs_chk (
  .aclk(aclk), .aresetn(aresetn), .end_trace_reset(end_trace_reset),
  .debug_module_enable(debug_module_enable),
  .trigger_begin_select(trigger_begin_select), .core_bus(core_bus),
  .trace_word_load(trace_word_load), .trace_word_info(trace_word_info),
  .comp_c_ext(comp_c_ext), .trace_ext(trace_ext),
  .comp_c_ext_hit(comp_c_ext_hit), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata));

// *** tb/debug_comparator_c_ext_and_fifo_ext_tb_top.sv ***
/*
  Self-checking bench: AXI4-Lite register access, comparator C qualifier
  table, trace word information and reset retention.
  Assumes the core bus model and the bound checker are compiled with it.
*/
module debug_comparator_c_ext_and_fifo_ext_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        aclk = 1'b0;
  logic                        aresetn = 1'b0;
  logic [7:0]                  awaddr = 8'h00;
  logic [7:0]                  araddr = 8'h00;
  logic [31:0]                 wdata = 32'h0;
  logic                        awvalid = 1'b0;
  logic                        wvalid = 1'b0;
  logic                        bready = 1'b0;
  logic                        arvalid = 1'b0;
  logic                        rready = 1'b0;
  logic                        etr = 1'b0;
  logic                        dme = 1'b0;
  logic                        tbs = 1'b0;
  logic                        awready, wready, bvalid, arready, rvalid;
  logic [1:0]                  bresp, rresp;
  logic [31:0]                 rdata;
  logic                        tw_load, hit;
  dbg_ext_pkg::core_bus_type   core_bus;
  dbg_ext_pkg::trace_ext_type  tw_info, trace_ext;
  dbg_ext_pkg::comp_c_ext_type comp_c_ext;
  int                          num_errors = 0;
  int                          checks = 0;
  // Entries: register value, read, paged, address bit 16, expected hit
  logic [11:0] tbl [11] = '{12'h001, 12'h009, 12'h00c, 12'h00a, 12'h801,
    12'h808, 12'hc09, 12'hc00, 12'hfff, 12'hffa, 12'h21c};

  always #2 aclk = ~aclk;

  dbg_ext_regs u_dbg_ext_regs (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .end_trace_reset(etr),
    .debug_module_enable(dme), .trigger_begin_select(tbs),
    .core_bus(core_bus), .trace_word_load(tw_load),
    .trace_word_info(tw_info), .comp_c_ext(comp_c_ext),
    .trace_ext(trace_ext), .comp_c_ext_hit(hit));

  core_bus_model u_core_bus_model (.aclk(aclk), .core_bus(core_bus),
    .trace_word_load(tw_load), .trace_word_info(tw_info));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 20) begin
      num_errors++;
      test_done();
    end
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  // Read: rready held until the data is seen
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 20) begin
      num_errors++;
      test_done();
    end
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // Hit is registered, so it is looked at half a cycle after the take
  task automatic probe(input logic [3:0] p);
    u_core_bus_model.drive(p[3], p[2], p[1]);
    @(negedge aclk);
    chk({31'h0, hit}, {31'h0, p[0]});
  endtask

  task automatic rst(input logic e, input logic d, input logic t);
    @(posedge aclk);
    etr <= e;
    dme <= d;
    tbs <= t;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Main sequence
  initial begin
    rst(1'b0, 1'b0, 1'b0);
    rd(8'h28, 32'h0, dbg_ext_pkg::RESP_OKAY);
    rd(8'h2c, 32'h0, dbg_ext_pkg::RESP_OKAY);
    for (int i = 0; i < 11; i++) begin
      wr(8'h28, {24'h0, tbl[i][11:4]}, dbg_ext_pkg::RESP_OKAY);
      rd(8'h28, {24'h0, tbl[i][11:4] & 8'he1}, dbg_ext_pkg::RESP_OKAY);
      probe(tbl[i][3:0]);
    end
    wr(8'h30, 32'h1, dbg_ext_pkg::RESP_SLVERR);
    rd(8'h30, 32'h0, dbg_ext_pkg::RESP_SLVERR);
    u_core_bus_model.load(1'b1, 1'b1);
    rd(8'h2c, 32'h81, dbg_ext_pkg::RESP_OKAY);
    wr(8'h2c, 32'h0, dbg_ext_pkg::RESP_OKAY);
    rd(8'h2c, 32'h81, dbg_ext_pkg::RESP_OKAY);
    u_core_bus_model.load(1'b0, 1'b1);
    rd(8'h2c, 32'h01, dbg_ext_pkg::RESP_OKAY);
    // End-trace reset with debug on and end trigger keeps both registers
    wr(8'h28, 32'ha1, dbg_ext_pkg::RESP_OKAY);
    u_core_bus_model.load(1'b1, 1'b1);
    rst(1'b1, 1'b1, 1'b0);
    rd(8'h28, 32'ha1, dbg_ext_pkg::RESP_OKAY);
    rd(8'h2c, 32'h81, dbg_ext_pkg::RESP_OKAY);
    rst(1'b1, 1'b1, 1'b1);
    rd(8'h28, 32'h0, dbg_ext_pkg::RESP_OKAY);
    rd(8'h2c, 32'h0, dbg_ext_pkg::RESP_OKAY);
    test_done();
  end
endmodule
